// *** bsf_bit_unit.sv ***
`timescale 1ns/1ps
module bsf_bit_unit
(
    input wire logic [7:0] value_in,
    input wire logic [2:0] index_in,
    input wire logic bit_in,
    output logic [7:0] value_out,
    output logic bit_out
);
    // ----------------------------------------
    // single bit replace and select
    // ----------------------------------------
    wire [7:0] bit_mask = 8'h01 << index_in;

    assign value_out = bit_in ? (value_in | bit_mask) : (value_in & ~bit_mask);
    assign bit_out = value_in[index_in];
endmodule

// *** bsf_datapath.sv ***
// Behaviour
// - push stores the source register on the stack; flags unchanged.
// - pop loads the destination register from the stack; flags unchanged.
// - io bit set forces one addressed I/O bit high, nothing else changes.
// - io bit clear forces one addressed I/O bit low, nothing else changes.
// - logical left shift moves bits up, zero enters bit zero.
// - logical right shift moves bits down, zero enters bit seven.
// - rotate left: old carry into bit zero, old bit seven into carry.
// - rotate right: old carry into bit seven, old bit zero into carry.
// - arithmetic right shift moves bits down, keeps bit seven.
// - flag index set or clear changes only the indexed flag.
// - bit store copies a source bit into the transfer flag only.
// - bit load copies the transfer flag into one destination bit.
// - carry set and clear write carry only.
// - negative set and clear write negative only.
// - zero set and clear write zero only.
// - interrupt enable sets the interrupt flag only.
// - interrupt disable clears the interrupt flag only.
//
// Design decisions made here: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/1ps
module bsf_datapath
#(
    parameter int DEPTH = bsf_pkg::STACK_DEPTH
)
(
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [2:0] hsize_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    output logic hreadyout_out,
    output logic hresp_out,
    output logic [31:0] hrdata_out,
    output logic [7:0] cpu_flags_out
);
    localparam int SP_W = $clog2(DEPTH) + 1;
    localparam int IX_W = $clog2(DEPTH);
    // ----------------------------------------
    // state
    // ----------------------------------------
    logic [7:0] dest;
    logic [7:0] src;
    logic [7:0] flags;
    logic [SP_W-1:0] sp;
    logic [7:0] stack_mem [DEPTH];
    logic [7:0] io_regs [bsf_pkg::IO_COUNT];
    logic wr_pend;
    logic [7:0] wr_addr;
    logic [7:0] next_dest;
    logic [7:0] next_src;
    logic [7:0] next_flags;
    logic [SP_W-1:0] next_sp;
    logic stack_we;
    // ----------------------------------------
    // bus decode
    // ----------------------------------------
    wire ahb_take = hsel_in & hready_in & htrans_in[1];
    wire [7:0] ra = haddr_in[7:0];
    wire cmd_wr = wr_pend & (wr_addr == bsf_pkg::OFF_CMD);
    wire dest_wr = wr_pend & (wr_addr == bsf_pkg::OFF_DEST);
    wire src_wr = wr_pend & (wr_addr == bsf_pkg::OFF_SRC);
    wire flags_wr = wr_pend & (wr_addr == bsf_pkg::OFF_FLAGS);
    wire io_bus_wr = wr_pend & ((wr_addr & bsf_pkg::IO_WINDOW_MASK) == bsf_pkg::OFF_IO_BASE);
    wire [4:0] io_bus_idx = wr_addr[6:2];
    wire [4:0] io_rd_idx = ra[6:2];
    // ----------------------------------------
    // command fields
    // ----------------------------------------
    wire bsf_pkg::bsf_op_t cmd_op = bsf_pkg::bsf_op_t'(hwdata_in[bsf_pkg::CMD_OP_LSB +: 5]);
    wire bsf_pkg::bsf_op_t exec_op = cmd_wr ? cmd_op : bsf_pkg::op_none;
    wire [2:0] cmd_bit = hwdata_in[bsf_pkg::CMD_BIT_LSB +: 3];
    wire [4:0] cmd_io = hwdata_in[bsf_pkg::CMD_IO_LSB +: bsf_pkg::IO_IDX_W];
    wire full = (sp == SP_W'(DEPTH));
    wire empty = (sp == '0);
    wire [IX_W-1:0] push_idx = sp[IX_W-1:0];
    wire [IX_W-1:0] pop_idx = IX_W'(sp - 1'b1);
    wire [7:0] pop_data = stack_mem[pop_idx];
    wire [7:0] io_sel_val = io_regs[cmd_io];
    wire src_bit = src[cmd_bit];
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    wire is_shift = (exec_op >= bsf_pkg::logical_left_shift_op)
        & (exec_op <= bsf_pkg::arith_right_shift_op);
    wire is_io_op = (exec_op == bsf_pkg::io_bit_set_op) | (exec_op == bsf_pkg::io_bit_clear_op);
    // flag index chosen by each flag operation
    function automatic logic [2:0] flag_of(input bsf_pkg::bsf_op_t op, input logic [2:0] b);
        case (op)
            bsf_pkg::bit_to_transfer_flag_op: flag_of = 3'(bsf_pkg::FLAG_T);
            bsf_pkg::carry_set_op, bsf_pkg::carry_clear_op: flag_of = 3'(bsf_pkg::FLAG_C);
            bsf_pkg::negative_set_op, bsf_pkg::negative_clear_op: flag_of = 3'(bsf_pkg::FLAG_N);
            bsf_pkg::zero_set_op, bsf_pkg::zero_clear_op: flag_of = 3'(bsf_pkg::FLAG_Z);
            bsf_pkg::interrupt_enable_op, bsf_pkg::interrupt_disable_op:
                flag_of = 3'(bsf_pkg::FLAG_I);
            default: flag_of = b;
        endcase
    endfunction
    // flag value written by each flag operation
    function automatic logic flag_val_of(input bsf_pkg::bsf_op_t op, input logic t_bit);
        case (op)
            bsf_pkg::flag_index_set_op, bsf_pkg::carry_set_op, bsf_pkg::negative_set_op,
            bsf_pkg::zero_set_op, bsf_pkg::interrupt_enable_op: flag_val_of = 1'b1;
            bsf_pkg::bit_to_transfer_flag_op: flag_val_of = t_bit;
            default: flag_val_of = 1'b0;
        endcase
    endfunction
    // ----------------------------------------
    // operation units
    // ----------------------------------------
    logic [7:0] shift_res;
    logic shift_c;
    logic shift_z;
    logic shift_n;
    logic shift_v;
    logic [7:0] io_upd;
    logic [7:0] bld_upd;
    logic [7:0] flag_upd;
    bsf_shift_unit u_shift
    (
        .op_in(exec_op), .value_in(dest), .carry_in(flags[bsf_pkg::FLAG_C]),
        .result_out(shift_res), .shift_carry_out(shift_c), .zero_out(shift_z),
        .negative_out(shift_n), .overflow_out(shift_v)
    );
    bsf_bit_unit u_io_bit
    (
        .value_in(io_sel_val), .index_in(cmd_bit), .bit_in(exec_op == bsf_pkg::io_bit_set_op),
        .value_out(io_upd), .bit_out()
    );
    bsf_bit_unit u_dest_bit
    (
        .value_in(dest), .index_in(cmd_bit), .bit_in(flags[bsf_pkg::FLAG_T]),
        .value_out(bld_upd), .bit_out()
    );
    bsf_bit_unit u_flag_bit
    (
        .value_in(flags), .index_in(flag_of(exec_op, cmd_bit)),
        .bit_in(flag_val_of(exec_op, src_bit)), .value_out(flag_upd), .bit_out()
    );
    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb
    begin
        next_dest = dest_wr ? hwdata_in[7:0] : dest;
        next_src = src_wr ? hwdata_in[7:0] : src;
        next_flags = flags_wr ? hwdata_in[7:0] : flags;
        next_sp = sp;
        stack_we = 1'b0;
        case (exec_op)
            bsf_pkg::op_push:
            begin
                stack_we = ~full;
                next_sp = full ? sp : SP_W'(sp + 1'b1);
            end
            bsf_pkg::op_pop:
            begin
                next_dest = empty ? dest : pop_data;
                next_sp = empty ? sp : SP_W'(sp - 1'b1);
            end
            bsf_pkg::transfer_flag_to_bit_op: next_dest = bld_upd;
            bsf_pkg::logical_left_shift_op, bsf_pkg::logical_right_shift_op,
            bsf_pkg::rotate_left_carry_op, bsf_pkg::rotate_right_carry_op,
            bsf_pkg::arith_right_shift_op:
            begin
                next_dest = shift_res;
                next_flags[bsf_pkg::FLAG_C] = shift_c;
                next_flags[bsf_pkg::FLAG_Z] = shift_z;
                next_flags[bsf_pkg::FLAG_N] = shift_n;
                next_flags[bsf_pkg::FLAG_V] = shift_v;
            end
            bsf_pkg::flag_index_set_op, bsf_pkg::flag_index_clear_op,
            bsf_pkg::bit_to_transfer_flag_op, bsf_pkg::carry_set_op, bsf_pkg::carry_clear_op,
            bsf_pkg::negative_set_op, bsf_pkg::negative_clear_op, bsf_pkg::zero_set_op,
            bsf_pkg::zero_clear_op, bsf_pkg::interrupt_enable_op,
            bsf_pkg::interrupt_disable_op:
                next_flags = flag_upd;
            default: next_dest = next_dest;
        endcase
    end
    // ----------------------------------------
    // registers
    // ----------------------------------------
    always_ff @(posedge clk_in)
    begin
        if (!resetn_in)
        begin
            dest <= bsf_pkg::DEST_RST;
            src <= bsf_pkg::SRC_RST;
            flags <= bsf_pkg::FLAGS_RST;
            sp <= '0;
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
        end
        else
        begin
            dest <= next_dest;
            src <= next_src;
            flags <= next_flags;
            sp <= next_sp;
            wr_pend <= ahb_take & hwrite_in;
            wr_addr <= ra;
        end
    end
    always_ff @(posedge clk_in)
    begin
        if (stack_we)
            stack_mem[push_idx] <= src;
    end
    // one I/O register per slot, written by bus or by bit operation
    genvar gi;
    generate
        for (gi = 0; gi < bsf_pkg::IO_COUNT; gi++)
        begin : g_io
            wire op_hit = is_io_op & (cmd_io == 5'(gi));
            wire bus_hit = io_bus_wr & (io_bus_idx == 5'(gi));
            always_ff @(posedge clk_in)
            begin
                if (!resetn_in)
                    io_regs[gi] <= bsf_pkg::IO_RST;
                else if (op_hit)
                    io_regs[gi] <= io_upd;
                else if (bus_hit)
                    io_regs[gi] <= hwdata_in[7:0];
            end
        end
    endgenerate
    // ----------------------------------------
    // read path
    // ----------------------------------------
    wire io_rd_fresh = is_io_op & (cmd_io == io_rd_idx);
    wire io_rd_bus = io_bus_wr & (io_bus_idx == io_rd_idx);
    wire [7:0] io_rd_val = io_rd_fresh ? io_upd : (io_rd_bus ? hwdata_in[7:0] : io_regs[io_rd_idx]);
    wire [31:0] stat_word = (32'(next_sp) | (32'(next_sp == SP_W'(DEPTH)) << bsf_pkg::STAT_FULL_BIT)
        | (32'(next_sp == '0) << bsf_pkg::STAT_EMPTY_BIT));
    wire [31:0] rd_word =
        ((ra & bsf_pkg::IO_WINDOW_MASK) == bsf_pkg::OFF_IO_BASE) ? {24'h000000, io_rd_val} :
        (ra == bsf_pkg::OFF_DEST) ? {24'h000000, next_dest} :
        (ra == bsf_pkg::OFF_SRC) ? {24'h000000, next_src} :
        (ra == bsf_pkg::OFF_FLAGS) ? {24'h000000, next_flags} :
        (ra == bsf_pkg::OFF_STACK) ? stat_word : 32'h00000000;
    always_ff @(posedge clk_in)
    begin
        if (!resetn_in)
            hrdata_out <= 32'h00000000;
        else
            hrdata_out <= (ahb_take & ~hwrite_in) ? rd_word : 32'h00000000;
    end
    assign hreadyout_out = 1'b1;
    assign hresp_out = 1'b0;
    assign cpu_flags_out = flags;
    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!resetn_in);
    property p_push;
        (exec_op == bsf_pkg::op_push) && !full
            |=> (stack_mem[$past(push_idx)] == $past(src)) && (flags == $past(flags))
            && (sp == $past(sp) + 1'b1);
    endproperty
    a_push: assert property (p_push) else $error("push did not store source");
    property p_pop;
        (exec_op == bsf_pkg::op_pop) && !empty
            |=> (dest == $past(pop_data)) && (flags == $past(flags));
    endproperty
    a_pop: assert property (p_pop) else $error("pop did not load destination");
    property p_io_set;
        (exec_op == bsf_pkg::io_bit_set_op)
            |=> (io_regs[$past(cmd_io)] == ($past(io_sel_val) | (8'h01 << $past(cmd_bit))))
            && $stable(flags);
    endproperty
    a_io_set: assert property (p_io_set) else $error("io bit set wrong");
    property p_io_clr;
        (exec_op == bsf_pkg::io_bit_clear_op)
            |=> (io_regs[$past(cmd_io)] == ($past(io_sel_val) & ~(8'h01 << $past(cmd_bit))))
            && $stable(flags);
    endproperty
    a_io_clr: assert property (p_io_clr) else $error("io bit clear wrong");
    property p_lsl;
        (exec_op == bsf_pkg::logical_left_shift_op)
            |=> (dest == {$past(dest[6:0]), 1'b0}) && (flags[bsf_pkg::FLAG_C] == $past(dest[7]));
    endproperty
    a_lsl: assert property (p_lsl) else $error("left shift wrong");
    property p_lsr;
        (exec_op == bsf_pkg::logical_right_shift_op) |=> (dest == {1'b0, $past(dest[7:1])});
    endproperty
    a_lsr: assert property (p_lsr) else $error("right shift wrong");
    property p_rol;
        (exec_op == bsf_pkg::rotate_left_carry_op)
            |=> (dest == {$past(dest[6:0]), $past(flags[bsf_pkg::FLAG_C])})
            && (flags[bsf_pkg::FLAG_C] == $past(dest[7]));
    endproperty
    a_rol: assert property (p_rol) else $error("rotate left wrong");
    property p_ror;
        (exec_op == bsf_pkg::rotate_right_carry_op)
            |=> (dest == {$past(flags[bsf_pkg::FLAG_C]), $past(dest[7:1])})
            && (flags[bsf_pkg::FLAG_C] == $past(dest[0]));
    endproperty
    a_ror: assert property (p_ror) else $error("rotate right wrong");
    property p_asr;
        (exec_op == bsf_pkg::arith_right_shift_op)
            |=> (dest == {$past(dest[7]), $past(dest[7:1])});
    endproperty
    a_asr: assert property (p_asr) else $error("arithmetic shift wrong");
    property p_flag_set;
        (exec_op == bsf_pkg::flag_index_set_op)
            |=> (flags == ($past(flags) | (8'h01 << $past(cmd_bit))));
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("flag set wrong");
    property p_bst;
        (exec_op == bsf_pkg::bit_to_transfer_flag_op)
            |=> (flags[bsf_pkg::FLAG_T] == $past(src_bit))
            && ((flags & 8'hBF) == ($past(flags) & 8'hBF));
    endproperty
    a_bst: assert property (p_bst) else $error("bit store wrong");
    property p_bld;
        (exec_op == bsf_pkg::transfer_flag_to_bit_op)
            |=> (dest[$past(cmd_bit)] == $past(flags[bsf_pkg::FLAG_T])) && $stable(flags);
    endproperty
    a_bld: assert property (p_bld) else $error("bit load wrong");
    property p_int_en;
        (exec_op == bsf_pkg::interrupt_enable_op) |=> (flags == ($past(flags) | 8'h80));
    endproperty
    a_int_en: assert property (p_int_en) else $error("interrupt enable wrong");
    property p_shift_flags;
        is_shift |=> (flags[bsf_pkg::FLAG_Z] == (dest == 8'h00))
            && (flags[bsf_pkg::FLAG_N] == dest[7])
            && (flags[bsf_pkg::FLAG_V] == (dest[7] ^ flags[bsf_pkg::FLAG_C]));
    endproperty
    a_shift_flags: assert property (p_shift_flags) else $error("shift flags wrong");
endmodule

// *** bsf_host_model.sv ***
`timescale 1ns/1ps
module bsf_host_model
(
    input wire logic clk_in,
    input wire logic hready_in,
    input wire logic [31:0] hrdata_in,
    output logic hsel_out,
    output logic [31:0] haddr_out,
    output logic [1:0] htrans_out,
    output logic hwrite_out,
    output logic [2:0] hsize_out,
    output logic [31:0] hwdata_out
);
    initial
    begin
        hsel_out = 1'b0;
        haddr_out = 32'h0;
        htrans_out = 2'h0;
        hwrite_out = 1'b0;
        hsize_out = 3'h2;
        hwdata_out = 32'h0;
    end

    // ----------------------------------------
    // one single word transfer
    // ----------------------------------------
    task automatic xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wdata,
                        output logic [31:0] rdata);
        hsel_out <= 1'b1;
        htrans_out <= 2'h2;
        haddr_out <= {24'h0, addr};
        hwrite_out <= wr;
        do @(posedge clk_in); while (hready_in !== 1'b1);
        htrans_out <= 2'h0;
        hwdata_out <= wr ? wdata : ~hwdata_out;
        do @(posedge clk_in); while (hready_in !== 1'b1);
        rdata = hrdata_in;
        hsel_out <= 1'b0;
        hwdata_out <= ~wdata;
        // idle edge: results settle before checks, no double drive
        @(posedge clk_in);
    endtask
endmodule

// *** bsf_pkg.sv ***
package bsf_pkg;
    // ----------------------------------------
    // widths and sizes
    // ----------------------------------------
    localparam int DATA_W = 8;
    localparam int IO_COUNT = 32;
    localparam int IO_IDX_W = 5;
    localparam int STACK_DEPTH = 16;
    localparam int ADDR_W = 8;

    // ----------------------------------------
    // register offsets
    // ----------------------------------------
    localparam logic [7:0] OFF_CMD = 8'h00;
    localparam logic [7:0] OFF_DEST = 8'h04;
    localparam logic [7:0] OFF_SRC = 8'h08;
    localparam logic [7:0] OFF_FLAGS = 8'h0C;
    localparam logic [7:0] OFF_STACK = 8'h10;
    localparam logic [7:0] OFF_IO_BASE = 8'h80;
    localparam logic [7:0] IO_WINDOW_MASK = 8'h80;

    // ----------------------------------------
    // command and status fields
    // ----------------------------------------
    localparam int CMD_OP_LSB = 0;
    localparam int CMD_BIT_LSB = 8;
    localparam int CMD_IO_LSB = 16;
    localparam int STAT_FULL_BIT = 16;
    localparam int STAT_EMPTY_BIT = 17;

    // ----------------------------------------
    // cpu_flag_register bit positions
    // ----------------------------------------
    localparam int FLAG_C = 0;
    localparam int FLAG_Z = 1;
    localparam int FLAG_N = 2;
    localparam int FLAG_V = 3;
    localparam int FLAG_S = 4;
    localparam int FLAG_H = 5;
    localparam int FLAG_T = 6;
    localparam int FLAG_I = 7;

    // ----------------------------------------
    // reset values
    // ----------------------------------------
    localparam logic [7:0] FLAGS_RST = 8'h00;
    localparam logic [7:0] DEST_RST = 8'h00;
    localparam logic [7:0] SRC_RST = 8'h00;
    localparam logic [7:0] IO_RST = 8'h00;

    // ----------------------------------------
    // operation codes
    // ----------------------------------------
    typedef enum logic [4:0] {
        op_none = 5'h00,
        op_push = 5'h01,
        op_pop = 5'h02,
        io_bit_set_op = 5'h03,
        io_bit_clear_op = 5'h04,
        logical_left_shift_op = 5'h05,
        logical_right_shift_op = 5'h06,
        rotate_left_carry_op = 5'h07,
        rotate_right_carry_op = 5'h08,
        arith_right_shift_op = 5'h09,
        flag_index_set_op = 5'h0A,
        flag_index_clear_op = 5'h0B,
        bit_to_transfer_flag_op = 5'h0C,
        transfer_flag_to_bit_op = 5'h0D,
        carry_set_op = 5'h0E,
        carry_clear_op = 5'h0F,
        negative_set_op = 5'h10,
        negative_clear_op = 5'h11,
        zero_set_op = 5'h12,
        zero_clear_op = 5'h13,
        interrupt_enable_op = 5'h14,
        interrupt_disable_op = 5'h15
    } bsf_op_t;
endpackage

// *** bsf_shift_unit.sv ***
`timescale 1ns/1ps
module bsf_shift_unit
(
    input wire bsf_pkg::bsf_op_t op_in,
    input wire logic [7:0] value_in,
    input wire logic carry_in,
    output logic [7:0] result_out,
    output logic shift_carry_out,
    output logic zero_out,
    output logic negative_out,
    output logic overflow_out
);
    // ----------------------------------------
    // shift and rotate
    // ----------------------------------------
    always_comb
    begin
        result_out = value_in;
        shift_carry_out = carry_in;
        case (op_in)
            bsf_pkg::logical_left_shift_op:
            begin
                result_out = {value_in[6:0], 1'b0};
                shift_carry_out = value_in[7];
            end
            bsf_pkg::logical_right_shift_op:
            begin
                result_out = {1'b0, value_in[7:1]};
                shift_carry_out = value_in[0];
            end
            bsf_pkg::rotate_left_carry_op:
            begin
                result_out = {value_in[6:0], carry_in};
                shift_carry_out = value_in[7];
            end
            bsf_pkg::rotate_right_carry_op:
            begin
                result_out = {carry_in, value_in[7:1]};
                shift_carry_out = value_in[0];
            end
            bsf_pkg::arith_right_shift_op:
            begin
                result_out = {value_in[7], value_in[7:1]};
                shift_carry_out = value_in[0];
            end
            default:
            begin
                result_out = value_in;
                shift_carry_out = carry_in;
            end
        endcase
    end

    // result flags
    assign zero_out = (result_out == 8'h00);
    assign negative_out = result_out[7];
    assign overflow_out = result_out[7] ^ shift_carry_out;
endmodule

// *** bsf_testbench.sv ***
`timescale 1ns/1ps
`define CHK(got, exp) \
    compares++; \
    if ((got) !== (exp)) \
    begin \
        error_cnt++; \
        $display("wrong value at %0t: got %0h exp %0h", $time, got, exp); \
    end
module testbench;
    logic clk_in = 1'b0;
    logic resetn_in = 1'b0;
    logic hsel, hwrite, hready, hresp;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [7:0] flags;
    int error_cnt = 0;
    int compares = 0;

    always #5 clk_in = ~clk_in;

    bsf_datapath uut (.clk_in(clk_in), .resetn_in(resetn_in), .hsel_in(hsel),
        .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize),
        .hwdata_in(hwdata), .hready_in(hready), .hreadyout_out(hready),
        .hresp_out(hresp), .hrdata_out(hrdata), .cpu_flags_out(flags));
    bsf_host_model host (.clk_in(clk_in), .hready_in(hready), .hrdata_in(hrdata),
        .hsel_out(hsel), .haddr_out(haddr), .htrans_out(htrans), .hwrite_out(hwrite),
        .hsize_out(hsize), .hwdata_out(hwdata));

    // ----------------------------------------
    // bus helpers
    // ----------------------------------------
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        host.xfer(1'b1, a, {24'h0, d}, rd);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        host.xfer(1'b0, a, 32'h0, rd);
        `CHK(rd, exp)
    endtask
    task automatic exec(input bsf_pkg::bsf_op_t op, input logic [2:0] b, input logic [4:0] io);
        host.xfer(1'b1, bsf_pkg::OFF_CMD, {11'h0, io, 5'h0, b, 3'h0, op}, rd);
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset;
        rdc(bsf_pkg::OFF_FLAGS, 32'h0);
        rdc(bsf_pkg::OFF_STACK, 32'h0002_0000);
        wr(8'h40, 8'hFF);
        rdc(8'h40, 32'h0);
        `CHK(hresp, 1'b0)
        $display("reset test done");
    endtask
    task automatic t_stack;
        wr(bsf_pkg::OFF_FLAGS, 8'h5A);
        wr(bsf_pkg::OFF_SRC, 8'hA5);
        exec(bsf_pkg::op_push, 3'h0, 5'h0);
        wr(bsf_pkg::OFF_SRC, 8'h3C);
        exec(bsf_pkg::op_push, 3'h0, 5'h0);
        exec(bsf_pkg::op_pop, 3'h0, 5'h0);
        rdc(bsf_pkg::OFF_DEST, 32'h3C);
        exec(bsf_pkg::op_pop, 3'h0, 5'h0);
        rdc(bsf_pkg::OFF_DEST, 32'hA5);
        exec(bsf_pkg::op_pop, 3'h0, 5'h0);
        rdc(bsf_pkg::OFF_DEST, 32'hA5);
        `CHK(flags, 8'h5A)
        $display("stack test done");
    endtask
    task automatic t_io;
        wr(8'h94, 8'h0F);
        exec(bsf_pkg::io_bit_set_op, 3'h7, 5'd5);
        rdc(8'h94, 32'h8F);
        exec(bsf_pkg::io_bit_clear_op, 3'h0, 5'd5);
        rdc(8'h94, 32'h8E);
        rdc(8'h98, 32'h0);
        `CHK(flags, 8'h5A)
        $display("io bit test done");
    endtask
    task automatic t_shift;
        bsf_pkg::bsf_op_t ops[5];
        logic [7:0] v, r, f;
        logic c, co;
        ops = '{bsf_pkg::logical_left_shift_op, bsf_pkg::logical_right_shift_op,
                bsf_pkg::rotate_left_carry_op, bsf_pkg::rotate_right_carry_op,
                bsf_pkg::arith_right_shift_op};
        for (int i = 0; i < 10; i++)
        begin
            v = (i < 5) ? 8'h81 : 8'h80;
            f = (i < 5) ? 8'hE1 : 8'h70;
            c = f[0];
            wr(bsf_pkg::OFF_FLAGS, f);
            wr(bsf_pkg::OFF_DEST, v);
            exec(ops[i % 5], 3'h0, 5'h0);
            case (i % 5)
                0: {co, r} = {v, 1'b0};
                1: {r, co} = {1'b0, v};
                2: {co, r} = {v, c};
                3: {r, co} = {c, v};
                default: {r, co} = {v[7], v};
            endcase
            f[bsf_pkg::FLAG_C] = co;
            f[bsf_pkg::FLAG_Z] = (r == 8'h00);
            f[bsf_pkg::FLAG_N] = r[7];
            f[bsf_pkg::FLAG_V] = r[7] ^ co;
            rdc(bsf_pkg::OFF_DEST, {24'h0, r});
            `CHK(flags, f)
        end
        $display("shift test done");
    endtask
    task automatic t_flags;
        bsf_pkg::bsf_op_t ops[8];
        int pos[8];
        ops = '{bsf_pkg::carry_set_op, bsf_pkg::carry_clear_op, bsf_pkg::negative_set_op,
                bsf_pkg::negative_clear_op, bsf_pkg::zero_set_op, bsf_pkg::zero_clear_op,
                bsf_pkg::interrupt_enable_op, bsf_pkg::interrupt_disable_op};
        pos = '{bsf_pkg::FLAG_C, bsf_pkg::FLAG_C, bsf_pkg::FLAG_N, bsf_pkg::FLAG_N,
                bsf_pkg::FLAG_Z, bsf_pkg::FLAG_Z, bsf_pkg::FLAG_I, bsf_pkg::FLAG_I};
        for (int i = 0; i < 8; i++)
        begin
            wr(bsf_pkg::OFF_FLAGS, 8'h00);
            exec(bsf_pkg::flag_index_set_op, 3'(i), 5'h0);
            `CHK(flags, 8'h01 << i)
            wr(bsf_pkg::OFF_FLAGS, 8'hFF);
            exec(bsf_pkg::flag_index_clear_op, 3'(i), 5'h0);
            `CHK(flags, ~(8'h01 << i))
            wr(bsf_pkg::OFF_FLAGS, (i % 2) ? 8'hFF : 8'h00);
            exec(ops[i], 3'h0, 5'h0);
            `CHK(flags, (i % 2) ? ~(8'h01 << pos[i]) : 8'h01 << pos[i])
        end
        $display("flag test done");
    endtask
    task automatic t_bits;
        wr(bsf_pkg::OFF_FLAGS, 8'h00);
        wr(bsf_pkg::OFF_SRC, 8'h20);
        wr(bsf_pkg::OFF_DEST, 8'h00);
        exec(bsf_pkg::bit_to_transfer_flag_op, 3'h5, 5'h0);
        `CHK(flags, 8'h40)
        exec(bsf_pkg::transfer_flag_to_bit_op, 3'h6, 5'h0);
        rdc(bsf_pkg::OFF_DEST, 32'h40);
        wr(bsf_pkg::OFF_FLAGS, 8'hFF);
        exec(bsf_pkg::bit_to_transfer_flag_op, 3'h4, 5'h0);
        `CHK(flags, 8'hBF)
        wr(bsf_pkg::OFF_DEST, 8'hFF);
        exec(bsf_pkg::transfer_flag_to_bit_op, 3'h2, 5'h0);
        rdc(bsf_pkg::OFF_DEST, 32'hFB);
        `CHK(flags, 8'hBF)
        $display("bit transfer test done");
    endtask

    // ----------------------------------------
    // verdict and sequence
    // ----------------------------------------
    task automatic give_verdict;
        $display("compares %0d mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    initial
    begin
        #200000;
        error_cnt++;
        give_verdict();
    end

    initial
    begin
        repeat (16) @(posedge clk_in);
        resetn_in <= 1'b1;
        @(posedge clk_in);
        t_reset();
        t_stack();
        t_io();
        t_shift();
        t_flags();
        t_bits();
        give_verdict();
    end
endmodule
